// ==== core/ppm_params.svh ====
// register offsets, field positions and reset values of the printer port pin block
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define PPM_OFS_CTRL      8'h00
`define PPM_OFS_STAT      8'h04
`define PPM_OFS_ODEN      8'h08
`define PPM_OFS_INT_STAT  8'h0c
`define PPM_OFS_INT_MASK  8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define PPM_BIT_STROBE    0
`define PPM_BIT_AUTOLF    1
`define PPM_BIT_INIT      2
`define PPM_BIT_SELECT    3
`define PPM_BIT_FAULT     3
`define PPM_BIT_EV_FALL   0
`define PPM_BIT_EV_RISE   1

// ****************************************************************
// reset values
// ****************************************************************
`define PPM_RST_CTRL      8'h04
`define PPM_RST_ODEN      4'h0
`define PPM_RST_MASK      2'h0

`endif

// ==== core/ppm_pkg.sv ====
// types shared by the printer port pin block
package ppm_pkg;

    // ****************************************************************
    // bus access phase
    // ****************************************************************
    typedef enum logic [1:0] {
        PPM_ACC_NONE  = 2'b00,
        PPM_ACC_READ  = 2'b01,
        PPM_ACC_WRITE = 2'b10
    } ppm_acc_e;

    typedef logic [7:0] ppm_byte_t;

endpackage : ppm_pkg

// ==== core/ppm_pin_drv.sv ====
// one printer control pin driver with push-pull or open-drain choice
`timescale 1ns/1ps
module ppm_pin_drv (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // control
    input  wire logic level_next,
    input  wire logic open_drain,
    // pin
    output logic      pin_out,
    output logic      pin_oe
);

    // ****************************************************************
    // registered pin drive
    // ****************************************************************
    // open-drain only pulls low; high is left to the cable pull-up
    wire logic oe_next = ~open_drain | ~level_next;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out <= 1'b1;
            pin_oe  <= 1'b1;
        end else begin
            pin_out <= level_next;
            pin_oe  <= oe_next;
        end
    end

endmodule : ppm_pin_drv

// ==== core/ppm_sync_edge.sv ====
// fault input edge detector producing rise and fall pulses
`timescale 1ns/1ps
module ppm_sync_edge (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // input level
    input  wire logic level_in,
    // outputs
    output logic      level_q,
    output logic      rise,
    output logic      fall
);

    // ****************************************************************
    // registered level and combinational edges
    // ****************************************************************
    // input is synchronous already; reset value assumes idle (no fault)
    logic prev_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= level_in;
        end
    end

    assign level_q = prev_reg;
    assign rise    = level_in & ~prev_reg;
    assign fall    = ~level_in & prev_reg;

endmodule : ppm_sync_edge

// ==== core/ppm_top.sv ====
// printer port pin mapping block with ahb-lite register slave
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_top (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // printer pins
    input  wire logic        printer_fault_in_n,
    output logic             printer_select_out_n,
    output logic             printer_select_oe,
    output logic             printer_init_out_n,
    output logic             printer_init_oe,
    output logic             auto_linefeed_out_n,
    output logic             auto_linefeed_oe,
    output logic             data_latch_pulse_n,
    output logic             data_latch_pulse_oe,
    // interrupt
    output logic             irq
);

    // ****************************************************************
    // registers
    // ****************************************************************
    ppm_pkg::ppm_byte_t ctrl_reg;
    logic [3:0]         oden_reg;
    logic [1:0]         int_stat_reg;
    logic [1:0]         int_mask_reg;
    ppm_pkg::ppm_acc_e  acc_reg;
    logic [7:0]         addr_reg;
    logic [31:0]        rdata_reg;
    logic               irq_reg;
    logic               ready_reg;
    logic               resp_reg;

    // ****************************************************************
    // address phase decode
    // ****************************************************************
    wire logic addr_take = hsel & hready & htrans[1];
    wire logic wr_phase  = (acc_reg == ppm_pkg::PPM_ACC_WRITE);
    wire logic wr_ctrl   = wr_phase & (addr_reg == `PPM_OFS_CTRL);
    wire logic wr_oden   = wr_phase & (addr_reg == `PPM_OFS_ODEN);
    wire logic wr_istat  = wr_phase & (addr_reg == `PPM_OFS_INT_STAT);
    wire logic wr_imask  = wr_phase & (addr_reg == `PPM_OFS_INT_MASK);

    ppm_pkg::ppm_acc_e acc_next;
    assign acc_next = !addr_take ? ppm_pkg::PPM_ACC_NONE :
                      hwrite     ? ppm_pkg::PPM_ACC_WRITE : ppm_pkg::PPM_ACC_READ;

    // ****************************************************************
    // fault input level and events
    // ****************************************************************
    logic fault_level;
    logic fault_rise;
    logic fault_fall;

    ppm_sync_edge u_fault (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .level_in (printer_fault_in_n),
        .level_q  (fault_level),
        .rise     (fault_rise),
        .fall     (fault_fall)
    );

    // status byte: only the fault bit is implemented, others read zero
    wire logic [7:0] stat_byte = {4'h0, fault_level, 3'h0};
    wire logic       printer_fault_level = stat_byte[`PPM_BIT_FAULT];

    // ****************************************************************
    // interrupt status: a new event wins over a clearing write
    // ****************************************************************
    wire logic [1:0] ev_now = {fault_rise, fault_fall};
    wire logic [1:0] clr_now = wr_istat ? hwdata[1:0] : 2'h0;
    wire logic [1:0] int_stat_next = (int_stat_reg & ~clr_now) | ev_now;
    wire logic       irq_next = |(int_stat_next & int_mask_reg);

    // ****************************************************************
    // write forwarding for reads
    // ****************************************************************
    // a read whose address phase meets the data phase of a write must return the new value
    ppm_pkg::ppm_byte_t ctrl_next;
    wire logic [3:0]    oden_next = wr_oden ? hwdata[3:0] : oden_reg;
    wire logic [1:0]    mask_next = wr_imask ? hwdata[1:0] : int_mask_reg;

    assign ctrl_next = wr_ctrl ? hwdata[7:0] : ctrl_reg;

    // ****************************************************************
    // read data select, taken in the address phase with any write of that cycle applied
    // ****************************************************************
    wire logic [31:0] rdata_next =
        (haddr == `PPM_OFS_CTRL)     ? {24'h0, ctrl_next} :
        (haddr == `PPM_OFS_STAT)     ? {24'h0, stat_byte} :
        (haddr == `PPM_OFS_ODEN)     ? {28'h0, oden_next} :
        (haddr == `PPM_OFS_INT_STAT) ? {30'h0, int_stat_next} :
        (haddr == `PPM_OFS_INT_MASK) ? {30'h0, mask_next} : 32'h0;

    // ****************************************************************
    // bus state and register writes
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_reg   <= ppm_pkg::PPM_ACC_NONE;
            addr_reg  <= 8'h00;
            rdata_reg <= 32'h0;
        end else begin
            acc_reg  <= acc_next;
            addr_reg <= haddr;
            if (addr_take && !hwrite) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg     <= `PPM_RST_CTRL;
            oden_reg     <= `PPM_RST_ODEN;
            int_mask_reg <= `PPM_RST_MASK;
            int_stat_reg <= 2'h0;
            irq_reg      <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= hwdata[7:0];
            end
            if (wr_oden) begin
                oden_reg <= hwdata[3:0];
            end
            if (wr_imask) begin
                int_mask_reg <= hwdata[1:0];
            end
            int_stat_reg <= int_stat_next;
            irq_reg      <= irq_next;
        end
    end

    // zero-wait slave; every response is okay; held in flops so every output leaves a register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_reg <= 1'b1;
            resp_reg  <= 1'b0;
        end else begin
            ready_reg <= 1'b1;
            resp_reg  <= 1'b0;
        end
    end

    assign hreadyout = ready_reg;
    assign hresp     = resp_reg;
    assign hrdata    = rdata_reg;
    assign irq       = irq_reg;

    // ****************************************************************
    // control pin mapping
    // ****************************************************************
    // next values come from the write data so the pins follow the register

    wire logic sel_lvl  = ~ctrl_next[`PPM_BIT_SELECT];
    wire logic init_lvl = ctrl_next[`PPM_BIT_INIT];
    wire logic alf_lvl  = ~ctrl_next[`PPM_BIT_AUTOLF];
    wire logic stb_lvl  = ~ctrl_next[`PPM_BIT_STROBE];

    ppm_pin_drv u_sel (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .level_next (sel_lvl),
        .open_drain (oden_reg[`PPM_BIT_SELECT]),
        .pin_out    (printer_select_out_n),
        .pin_oe     (printer_select_oe)
    );

    ppm_pin_drv u_init (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .level_next (init_lvl),
        .open_drain (oden_reg[`PPM_BIT_INIT]),
        .pin_out    (printer_init_out_n),
        .pin_oe     (printer_init_oe)
    );

    ppm_pin_drv u_alf (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .level_next (alf_lvl),
        .open_drain (oden_reg[`PPM_BIT_AUTOLF]),
        .pin_out    (auto_linefeed_out_n),
        .pin_oe     (auto_linefeed_oe)
    );

    ppm_pin_drv u_stb (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .level_next (stb_lvl),
        .open_drain (oden_reg[`PPM_BIT_STROBE]),
        .pin_out    (data_latch_pulse_n),
        .pin_oe     (data_latch_pulse_oe)
    );

    // ****************************************************************
    // assertions
    // ****************************************************************
    AST_FAULT_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        printer_fault_level == $past(printer_fault_in_n))
        else $error("status fault bit does not follow the fault input");

    AST_SELECT_INV: assert property (@(posedge hclk) disable iff (!hresetn)
        printer_select_out_n == ~ctrl_reg[3])
        else $error("select output is not the inverse of control bit 3");

    AST_INIT_DIRECT: assert property (@(posedge hclk) disable iff (!hresetn)
        printer_init_out_n == ctrl_reg[2])
        else $error("init output is not control bit 2");

    AST_ALF_INV: assert property (@(posedge hclk) disable iff (!hresetn)
        auto_linefeed_out_n == ~ctrl_reg[1])
        else $error("auto line feed output is not the inverse of control bit 1");

    AST_STROBE_INV: assert property (@(posedge hclk) disable iff (!hresetn)
        data_latch_pulse_n == ~ctrl_reg[0])
        else $error("strobe output is not the inverse of control bit 0");

    AST_STROBE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> (data_latch_pulse_n == ~$past(hwdata[0])))
        else $error("strobe output did not follow a control write");

    AST_OD_HIGH_FLOAT: assert property (@(posedge hclk) disable iff (!hresetn)
        (oden_reg[3] && $stable(oden_reg) && printer_select_out_n) |-> !printer_select_oe)
        else $error("open-drain select drives high");

    AST_PP_DRIVES: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(oden_reg[0]) == 1'b0) |-> data_latch_pulse_oe)
        else $error("push-pull strobe not driven");

    AST_IRQ_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
        (int_mask_reg == 2'h0 && $past(int_mask_reg) == 2'h0) |-> !irq)
        else $error("interrupt raised while fully masked");

    // open-drain checks skip cycles in which the enable register moves, since the pins lag it by one clock
    AST_WR_SELECT: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> (printer_select_out_n == ~$past(hwdata[3])))
        else $error("select output did not follow a control write");

    AST_WR_INIT: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> (printer_init_out_n == $past(hwdata[2])))
        else $error("init output did not follow a control write");

    AST_WR_ALF: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> (auto_linefeed_out_n == ~$past(hwdata[1])))
        else $error("auto line feed output did not follow a control write");

    AST_INIT_OD_FLOAT: assert property (@(posedge hclk) disable iff (!hresetn)
        (oden_reg[2] && $stable(oden_reg) && printer_init_out_n) |-> !printer_init_oe)
        else $error("open-drain init drives high");

    AST_ALF_OD_FLOAT: assert property (@(posedge hclk) disable iff (!hresetn)
        (oden_reg[1] && $stable(oden_reg) && auto_linefeed_out_n) |-> !auto_linefeed_oe)
        else $error("open-drain auto line feed drives high");

    AST_STROBE_OD_FLOAT: assert property (@(posedge hclk) disable iff (!hresetn)
        (oden_reg[0] && $stable(oden_reg) && data_latch_pulse_n) |-> !data_latch_pulse_oe)
        else $error("open-drain strobe drives high");

    AST_PP_SELECT: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(oden_reg[3]) == 1'b0) |-> printer_select_oe)
        else $error("push-pull select not driven");

    AST_PP_INIT: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(oden_reg[2]) == 1'b0) |-> printer_init_oe)
        else $error("push-pull init not driven");

    AST_EV_FALL_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        fault_fall |=> int_stat_reg[`PPM_BIT_EV_FALL])
        else $error("falling fault edge did not set its status bit");

    AST_EV_RISE_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        fault_rise |=> int_stat_reg[`PPM_BIT_EV_RISE])
        else $error("rising fault edge did not set its status bit");

    AST_STAT_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_istat && hwdata[0] && !fault_fall) |=> !int_stat_reg[`PPM_BIT_EV_FALL])
        else $error("writing one did not clear the fall status bit");

    AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        irq == |(int_stat_reg & $past(int_mask_reg)))
        else $error("interrupt level does not match masked status");

endmodule : ppm_top

// ==== dv/ppm_printer_model.sv ====
// printer on the far side of the port: pulled-up control lines and a fault output
`timescale 1ns/1ps
module ppm_printer_model (
    // pins from the block
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    // command from the bench
    input  wire logic       fault_cmd,
    // resolved lines and fault pin
    output logic      [3:0] line_lvl,
    output logic            printer_fault_in_n
);
    // ****************************************************************
    // line resolution
    // ****************************************************************
    // a released open-drain line is pulled up, so it reads 1 rather than the last driven level
    assign line_lvl = (pin_out & pin_oe) | ~pin_oe;
    // fault pin is active low: a commanded fault pulls it low
    assign printer_fault_in_n = ~fault_cmd;
endmodule : ppm_printer_model

// ==== dv/ppm_top_tb_top.sv ====
// self-checking bench for the printer port pin block
`timescale 1ns/1ps
`include "ppm_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ppm_top_tb_top;
    logic        hclk, hresetn, hsel, hwrite, fault_cmd;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic        hreadyout, hresp, irq;
    logic        resp_seen;
    logic [3:0]  pin_out, pin_oe, line_lvl, lv;
    logic        fault_n;
    int          n_mismatch, checks;

    ppm_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .printer_fault_in_n(fault_n),
        .printer_select_out_n(pin_out[3]), .printer_select_oe(pin_oe[3]),
        .printer_init_out_n(pin_out[2]), .printer_init_oe(pin_oe[2]),
        .auto_linefeed_out_n(pin_out[1]), .auto_linefeed_oe(pin_oe[1]),
        .data_latch_pulse_n(pin_out[0]), .data_latch_pulse_oe(pin_oe[0]), .irq(irq));
    ppm_printer_model prn_u (.pin_out(pin_out), .pin_oe(pin_oe), .fault_cmd(fault_cmd),
        .line_lvl(line_lvl), .printer_fault_in_n(fault_n));

    // ****************************************************************
    // clock, reset and bus cycles
    // ****************************************************************
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // one single word transfer launched just after a rising edge; only the watchdog ends a wait
    task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= is_wr;
        htrans <= 2'b10;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        d = hrdata;
        resp_seen = hresp;
        hsel <= 1'b0;
    endtask : xfer

    // write then read of one register, the read address phase inside the write data phase
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'b10;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        hwrite <= 1'b0;
        hwdata <= wd;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        d = hrdata;
        hsel <= 1'b0;
    endtask : wr_rd

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b1, a, wd, d);
        repeat (2) @(posedge hclk);
        #1;
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000, rd);
        `CHK(nm, e, rd)
        `CHK("hresp", 1'b0, resp_seen)
    endtask : rdchk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************************************
    // tests
    // ****************************************************************
    // bus reaches the block within a few cycles, so this span only trips on a hang
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00; hwrite = 1'b0;
        hwdata = 32'h0000_0000; fault_cmd = 1'b0; n_mismatch = 0; checks = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        `CHK("reset pins", 4'hf, pin_out)
        `CHK("reset oe", 4'hf, pin_oe)
        rdchk("reset ctrl", `PPM_OFS_CTRL, 32'h0000_0004);
        rdchk("unmapped", 8'h20, 32'h0000_0000);
        // every value of the four pin control bits, push-pull then open-drain on all four pins
        for (int od = 0; od < 2; od++) begin
            wr(`PPM_OFS_ODEN, od ? 32'h0000_000f : 32'h0000_0000);
            for (int v = 0; v < 16; v++) begin
                wr(`PPM_OFS_CTRL, 32'(v));
                lv = {~v[3], v[2], ~v[1], ~v[0]};
                `CHK("pin levels", lv, line_lvl)
                `CHK("pin oe", od ? ~lv : 4'hf, pin_oe)
                if (od == 0) `CHK("pin out", lv, pin_out)
            end
        end
        rdchk("ctrl rb", `PPM_OFS_CTRL, 32'h0000_000f);
        rdchk("oden rb", `PPM_OFS_ODEN, 32'h0000_000f);
        wr_rd(`PPM_OFS_CTRL, 32'h0000_0005, rd);
        `CHK("ctrl fwd", 32'h0000_0005, rd)
        // fault input: status level, sticky events, mask and clear
        wr(`PPM_OFS_INT_MASK, 32'h0000_0001);
        rdchk("mask rb", `PPM_OFS_INT_MASK, 32'h0000_0001);
        wr(`PPM_OFS_STAT, 32'h0000_0000);
        rdchk("stat idle", `PPM_OFS_STAT, 32'h0000_0008);
        @(posedge hclk) fault_cmd <= 1'b1;
        repeat (4) @(posedge hclk);
        #1;
        `CHK("irq fault", 1'b1, irq)
        rdchk("stat fault", `PPM_OFS_STAT, 32'h0000_0000);
        rdchk("ev fall", `PPM_OFS_INT_STAT, 32'h0000_0001);
        wr(`PPM_OFS_INT_STAT, 32'h0000_0001);
        `CHK("irq clr", 1'b0, irq)
        @(posedge hclk) fault_cmd <= 1'b0;
        repeat (4) @(posedge hclk);
        #1;
        `CHK("irq masked", 1'b0, irq)
        rdchk("ev rise", `PPM_OFS_INT_STAT, 32'h0000_0002);
        rdchk("stat clear", `PPM_OFS_STAT, 32'h0000_0008);
        tally_and_finish();
    end
endmodule : ppm_top_tb_top
